// ===== design/pin_override_pkg.sv
// Purpose: shared constants and types for the port E/F/G override logic
// Assumes: one override record per pad, combined with port register bits
// Notes: bit positions name the pads that carry alternate functions
package pin_override_pkg;
  localparam int PORT_WIDTH = 8;
  // port E pad positions
  localparam int PE_RECEIVE = 0;
  localparam int PE_TRANSMIT = 1;
  localparam int PE_SYNC_CLOCK = 2;
  localparam int PE_CMP_NEG = 3;
  localparam int PE_SERIAL_CLOCK = 4;
  localparam int PE_SERIAL_DATA = 5;
  localparam int PE_DATA_OUT = 6;
  localparam int PE_CLOCK_OUT = 7;
  // port F test access pad positions
  localparam int PF_TEST_CLOCK = 4;
  localparam int PF_TEST_SELECT = 5;
  localparam int PF_TEST_DATA_OUT = 6;
  localparam int PF_TEST_DATA_IN = 7;
  // port G reset-shared pad position
  localparam int PG_RESET_PIN = 5;
  // reset value of the registered pad controls
  localparam logic [7:0] PAD_RESET = 8'h00;
  // per-pad override record
  typedef struct packed {
    logic puOvrEn;
    logic puOvrVal;
    logic ddOvrEn;
    logic ddOvrVal;
    logic pvOvrEn;
    logic pvOvrVal;
    logic ptOvrEn;
    logic dieOvrEn;
    logic dieOvrVal;
  } override_s;
endpackage : pin_override_pkg

// ===== design/pad_override_if.sv
// Purpose: carries override records of one port between modules
// Assumes: eight pads per port
// Notes: source drives, pad cell consumes
`timescale 1ns/1ps
interface pad_override_if;
  import pin_override_pkg::*;
  override_s ovr [PORT_WIDTH];
  modport source (output ovr);
  modport sink (input ovr);
endinterface : pad_override_if

// ===== design/pad_port_cell.sv
// Purpose: one port's pad logic, port bits merged with override records
// Assumes: port registers are inputs; outputs registered on clk_sys
// Notes: toggle strobe flips the stored output value
`timescale 1ns/1ps
module pad_port_cell
  import pin_override_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  pad_override_if.sink ovrIf,
  input wire logic [WIDTH-1:0] portOut,
  input wire logic [WIDTH-1:0] portDir,
  input wire logic globalPullupDisable,
  output logic [WIDTH-1:0] padOe,
  output logic [WIDTH-1:0] padOut,
  output logic [WIDTH-1:0] padPullup,
  output logic [WIDTH-1:0] padInEn
);
  logic [WIDTH-1:0] oe_d, oe_q, out_d, out_q, pu_d, pu_q, ie_d, ie_q;
  logic [WIDTH-1:0] tog_d, tog_q;

  // each pad picks override or port value per control, override or 1 for input enable
  for (genvar i = 0; i < WIDTH; i++) begin : g_pad
    always_comb begin
      override_s o;
      o = ovrIf.ovr[i];
      oe_d[i] = o.ddOvrEn ? o.ddOvrVal : portDir[i];
      tog_d[i] = tog_q[i] ^ o.ptOvrEn; // strobe flips the pad value
      out_d[i] = (o.pvOvrEn ? o.pvOvrVal : portOut[i]) ^ tog_d[i];
      pu_d[i] = o.puOvrEn ? o.puOvrVal
                : (portOut[i] & ~portDir[i] & ~globalPullupDisable);
      ie_d[i] = o.dieOvrEn ? o.dieOvrVal : 1'b1;
    end
  end

  // register pad controls
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      oe_q <= PAD_RESET;
      out_q <= PAD_RESET;
      pu_q <= PAD_RESET;
      ie_q <= PAD_RESET;
      tog_q <= PAD_RESET;
    end else begin
      oe_q <= oe_d;
      out_q <= out_d;
      pu_q <= pu_d;
      ie_q <= ie_d;
      tog_q <= tog_d;
    end
  end

  assign padOe = oe_q;
  assign padOut = out_q;
  assign padPullup = pu_q;
  assign padInEn = ie_q;
endmodule : pad_port_cell

// ===== design/port_efg_override.sv
// Purpose: alternate-function overrides for ports E, F and G
// Assumes: peripheral enables synchronous to clk_sys; tap state given as flags
// Notes: pad controls are registered, one cycle after inputs change, except the io clock, tap and reset-shared pull-up patches
`timescale 1ns/1ps
module port_efg_override
  import pin_override_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clkIo,
  input wire logic [7:0] portEOut,
  input wire logic [7:0] portEDir,
  input wire logic [7:0] portFOut,
  input wire logic [7:0] portFDir,
  input wire logic [7:0] portGOut,
  input wire logic [7:0] portGDir,
  input wire logic globalPullupDisable,
  input wire logic receiverEnable,
  input wire logic transmitterEnable,
  input wire logic transmitSerialOut,
  input wire logic usartSyncMode,
  input wire logic syncClockOut,
  input wire logic clockOutputFuse,
  input wire logic serialIfaceTwoWireMode,
  input wire logic serialIfaceThreeWireMode,
  input wire logic serialDataOut,
  input wire logic serialDataLow,
  input wire logic serialClockHold,
  input wire logic serialClockToggleStrobe,
  input wire logic startConditionIrqEnable,
  input wire logic pinChangeGroup0Enable,
  input wire logic [7:0] pinChangeSourceE,
  input wire logic comparatorNegDigitalDisable,
  input wire logic comparatorPosDigitalDisable,
  input wire logic testPortEnable,
  input wire logic tapShiftInstructionState,
  input wire logic tapShiftDataState,
  input wire logic testDataOut,
  input wire logic [7:0] padEIn,
  input wire logic [7:0] padFIn,
  output logic [7:0] padEOe,
  output logic [7:0] padEOut,
  output logic [7:0] padEPullup,
  output logic [7:0] padEInEn,
  output logic [7:0] padFOe,
  output logic [7:0] padFOut,
  output logic [7:0] padFPullup,
  output logic [7:0] padFInEn,
  output logic [7:0] padGOe,
  output logic [7:0] padGOut,
  output logic [7:0] padGPullup,
  output logic [7:0] padGInEn,
  output logic usartReceiveData,
  output logic usartSyncClockIn,
  output logic testDataIn,
  output logic testModeSelect,
  output logic testClock
);
  pad_override_if ovrE ();
  pad_override_if ovrF ();
  pad_override_if ovrG ();
  logic [7:0] pcEnE;
  logic tdoDrive;
  // raw cell outputs; the bypassed pads are patched after the registers
  logic [7:0] fOeRaw, fOutRaw, gPuRaw;
  logic [7:0] fPuRaw;
  logic [7:0] padEOutRaw;

  // a source counts only while its pin-change group is enabled
  assign pcEnE = pinChangeSourceE & {8{pinChangeGroup0Enable}};

  // port E overrides
  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      ovrE.ovr[i] = '0;
      ovrE.ovr[i].dieOvrEn = pcEnE[i];
      ovrE.ovr[i].dieOvrVal = 1'b1;
    end
    // receive pad: forced input, pull-up from port bit
    ovrE.ovr[PE_RECEIVE].puOvrEn = receiverEnable;
    ovrE.ovr[PE_RECEIVE].puOvrVal = portEOut[PE_RECEIVE]
                                    & ~globalPullupDisable;
    ovrE.ovr[PE_RECEIVE].ddOvrEn = receiverEnable;
    // transmit pad
    ovrE.ovr[PE_TRANSMIT].puOvrEn = transmitterEnable;
    ovrE.ovr[PE_TRANSMIT].ddOvrEn = transmitterEnable;
    ovrE.ovr[PE_TRANSMIT].ddOvrVal = 1'b1;
    ovrE.ovr[PE_TRANSMIT].pvOvrEn = transmitterEnable;
    ovrE.ovr[PE_TRANSMIT].pvOvrVal = transmitSerialOut;
    // sync clock pad: drive only when sync mode and direction set
    ovrE.ovr[PE_SYNC_CLOCK].pvOvrEn = usartSyncMode & portEDir[PE_SYNC_CLOCK];
    ovrE.ovr[PE_SYNC_CLOCK].pvOvrVal = syncClockOut;
    ovrE.ovr[PE_SYNC_CLOCK].puOvrEn = usartSyncMode & portEDir[PE_SYNC_CLOCK];
    ovrE.ovr[PE_SYNC_CLOCK].dieOvrEn = pcEnE[PE_SYNC_CLOCK] | comparatorPosDigitalDisable;
    ovrE.ovr[PE_SYNC_CLOCK].dieOvrVal = pcEnE[PE_SYNC_CLOCK];
    // comparator negative pad
    ovrE.ovr[PE_CMP_NEG].dieOvrEn = pcEnE[PE_CMP_NEG] | comparatorNegDigitalDisable;
    ovrE.ovr[PE_CMP_NEG].dieOvrVal = pcEnE[PE_CMP_NEG];
    // two-wire clock pad
    ovrE.ovr[PE_SERIAL_CLOCK].puOvrEn = serialIfaceTwoWireMode;
    ovrE.ovr[PE_SERIAL_CLOCK].ddOvrEn = serialIfaceTwoWireMode;
    ovrE.ovr[PE_SERIAL_CLOCK].ddOvrVal = (serialClockHold | portEOut[PE_SERIAL_CLOCK])
                                         & portEDir[PE_SERIAL_CLOCK];
    ovrE.ovr[PE_SERIAL_CLOCK].pvOvrEn = serialIfaceTwoWireMode & portEDir[PE_SERIAL_CLOCK];
    ovrE.ovr[PE_SERIAL_CLOCK].ptOvrEn = serialClockToggleStrobe;
    ovrE.ovr[PE_SERIAL_CLOCK].dieOvrEn = pcEnE[PE_SERIAL_CLOCK]
                                         | startConditionIrqEnable;
    // two-wire data pad
    ovrE.ovr[PE_SERIAL_DATA].puOvrEn = serialIfaceTwoWireMode;
    ovrE.ovr[PE_SERIAL_DATA].ddOvrEn = serialIfaceTwoWireMode;
    ovrE.ovr[PE_SERIAL_DATA].ddOvrVal = (serialDataLow | portEOut[PE_SERIAL_DATA])
                                        & portEDir[PE_SERIAL_DATA];
    ovrE.ovr[PE_SERIAL_DATA].pvOvrEn = serialIfaceTwoWireMode
                                       & portEDir[PE_SERIAL_DATA];
    ovrE.ovr[PE_SERIAL_DATA].dieOvrEn = pcEnE[PE_SERIAL_DATA]
                                        | startConditionIrqEnable;
    // three-wire data output pad
    ovrE.ovr[PE_DATA_OUT].pvOvrEn = serialIfaceThreeWireMode;
    ovrE.ovr[PE_DATA_OUT].pvOvrVal = serialDataOut;
    // clock output pad; io clock is muxed after the register
    ovrE.ovr[PE_CLOCK_OUT].ddOvrEn = clockOutputFuse;
    ovrE.ovr[PE_CLOCK_OUT].ddOvrVal = 1'b1;
  end

  // port F: tap pads claimed when the test port is enabled
  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      ovrF.ovr[i] = '0;
      if (i >= PF_TEST_CLOCK) begin
        ovrF.ovr[i].puOvrEn = testPortEnable;
        ovrF.ovr[i].puOvrVal = 1'b1;
        ovrF.ovr[i].ddOvrEn = testPortEnable;
        ovrF.ovr[i].dieOvrEn = testPortEnable;
        ovrF.ovr[i].dieOvrVal = (i == PF_TEST_CLOCK);
      end
    end
    // tdo drives only while a shift state is active
    ovrF.ovr[PF_TEST_DATA_OUT].ddOvrVal = tapShiftInstructionState
                                          | tapShiftDataState;
    ovrF.ovr[PF_TEST_DATA_OUT].pvOvrEn = testPortEnable;
    ovrF.ovr[PF_TEST_DATA_OUT].pvOvrVal = testDataOut;
  end

  // port G: reset-shared pad is input only
  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      ovrG.ovr[i] = '0;
    end
    // pull-up forced on, driver forced off
    ovrG.ovr[PG_RESET_PIN].puOvrEn = 1'b1;
    ovrG.ovr[PG_RESET_PIN].puOvrVal = 1'b1;
    ovrG.ovr[PG_RESET_PIN].ddOvrEn = 1'b1;
  end

  pad_port_cell #(.WIDTH(PORT_WIDTH)) u_padE (
    .clk_sys(clk_sys), .rstn(rstn), .ovrIf(ovrE.sink),
    .portOut(portEOut), .portDir(portEDir),
    .globalPullupDisable(globalPullupDisable),
    .padOe(padEOe), .padOut(padEOutRaw), .padPullup(padEPullup), .padInEn(padEInEn)
  );
  pad_port_cell #(.WIDTH(PORT_WIDTH)) u_padF (
    .clk_sys(clk_sys), .rstn(rstn), .ovrIf(ovrF.sink),
    .portOut(portFOut), .portDir(portFDir),
    .globalPullupDisable(globalPullupDisable),
    .padOe(fOeRaw), .padOut(fOutRaw), .padPullup(fPuRaw), .padInEn(padFInEn)
  );
  pad_port_cell #(.WIDTH(PORT_WIDTH)) u_padG (
    .clk_sys(clk_sys), .rstn(rstn), .ovrIf(ovrG.sink),
    .portOut(portGOut), .portDir(portGDir),
    .globalPullupDisable(globalPullupDisable),
    .padOe(padGOe), .padOut(padGOut), .padPullup(gPuRaw), .padInEn(padGInEn)
  );

  // io clock bypasses the register so the pin shows the real clock
  always_comb begin
    padEOut = padEOutRaw;
    padEOut[PE_CLOCK_OUT] = clockOutputFuse ? clkIo : padEOutRaw[PE_CLOCK_OUT];
  end

  // tap pin drivers and pull-ups bypass registers (input enables stay registered): they must hold through reset and follow tck
  always_comb begin
    tdoDrive = tapShiftInstructionState | tapShiftDataState;
    padFOe = fOeRaw;
    padFOut = fOutRaw;
    padFPullup = fPuRaw;
    if (testPortEnable) begin
      padFPullup[7:4] = 4'hF;
      padFOe[7:4] = {1'b0, tdoDrive, 2'b00};
      // not shifting: driver off, the pull-up holds the line high
      padFOut[PF_TEST_DATA_OUT] = tdoDrive ? testDataOut : 1'b1;
    end
  end

  // reset-shared pull-up held on even during reset
  always_comb begin
    padGPullup = gPuRaw;
    padGPullup[PG_RESET_PIN] = 1'b1;
  end

  // alternate inputs; tap ones are raw pins used on tck by the tap
  assign usartReceiveData = padEIn[PE_RECEIVE];
  assign usartSyncClockIn = padEIn[PE_SYNC_CLOCK];
  assign testDataIn = testPortEnable & padFIn[PF_TEST_DATA_IN];
  assign testModeSelect = testPortEnable & padFIn[PF_TEST_SELECT];
  assign testClock = testPortEnable & padFIn[PF_TEST_CLOCK];
endmodule : port_efg_override

// ===== test/port_efg_override_chk.sv
// Purpose: concurrent checks on the port E/F/G pad override outputs
// Assumes: registered pad controls follow inputs one clk_sys edge later
// Notes: bound to the top module below
`timescale 1ns/1ps
module port_efg_override_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clkIo,
  input wire logic [7:0] portEOut,
  input wire logic [7:0] portEDir,
  input wire logic globalPullupDisable,
  input wire logic receiverEnable,
  input wire logic transmitterEnable,
  input wire logic transmitSerialOut,
  input wire logic usartSyncMode,
  input wire logic syncClockOut,
  input wire logic clockOutputFuse,
  input wire logic serialIfaceTwoWireMode,
  input wire logic serialDataLow,
  input wire logic serialClockToggleStrobe,
  input wire logic startConditionIrqEnable,
  input wire logic pinChangeGroup0Enable,
  input wire logic [7:0] pinChangeSourceE,
  input wire logic comparatorNegDigitalDisable,
  input wire logic testPortEnable,
  input wire logic tapShiftInstructionState,
  input wire logic tapShiftDataState,
  input wire logic [7:0] padFIn,
  input wire logic [7:0] padEOe,
  input wire logic [7:0] padEOut,
  input wire logic [7:0] padEPullup,
  input wire logic [7:0] padEInEn,
  input wire logic [7:0] padFOe,
  input wire logic [7:0] padFOut,
  input wire logic [7:0] padGOe,
  input wire logic [7:0] padGPullup,
  input wire logic testDataIn,
  input wire logic testModeSelect,
  input wire logic testClock
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // toggle only visible while the port bit and mode hold still
  sequence togPulse;
    serialClockToggleStrobe && $stable(portEOut[4]) && !serialIfaceTwoWireMode &&
      !$past(serialIfaceTwoWireMode) && $past(rstn);
  endsequence
  sequence clkoOut;
    (padEOut[7] == clkIo) ##1 padEOe[7];
  endsequence
  sclk_mode_a: assert property (1'b1 |=> padEOe[2] == $past(portEDir[2]) &&
      padEOut[2] == $past(usartSyncMode && portEDir[2] ? syncClockOut : portEOut[2]))
    else $error("sync clock pad wrong");
  rx_pullup_a: assert property (receiverEnable && portEOut[0] && !globalPullupDisable
      |=> padEPullup[0] && !padEOe[0]) else $error("receive pad pull-up off");
  tx_drive_a: assert property (transmitterEnable |=> padEOe[1] && !padEPullup[1] &&
      padEOut[1] == $past(transmitSerialOut)) else $error("transmit pad wrong");
  sda_ovr_a: assert property (serialIfaceTwoWireMode |=> !padEPullup[5] &&
      padEOe[5] == $past((serialDataLow | portEOut[5]) & portEDir[5]) &&
      (!padEOut[5] || !$past(portEDir[5]))) else $error("data pad wrong");
  scl_toggle_a: assert property (togPulse |=> padEOut[4] != $past(padEOut[4]))
    else $error("clock pad did not toggle");
  tw_input_a: assert property (startConditionIrqEnable ||
      (pinChangeGroup0Enable && pinChangeSourceE[5]) |=> padEInEn[5]) else $error("input off");
  cmp_din_a: assert property (comparatorNegDigitalDisable |=> padEInEn[3] ==
      $past(pinChangeSourceE[3] && pinChangeGroup0Enable)) else $error("cmp input wrong");
  clko_a: assert property (clockOutputFuse |-> clkoOut)
    else $error("clock output pad wrong");
  tdo_drive_a: assert property (testPortEnable |-> padFOe[6] ==
      (tapShiftInstructionState || tapShiftDataState) && (padFOe[6] || padFOut[6]))
    else $error("test data out wrong");
  tap_in_a: assert property (testPortEnable |->
      testDataIn == padFIn[7] && testModeSelect == padFIn[5] && testClock == padFIn[4] &&
      !padFOe[7] && !padFOe[5])
    else $error("tap inputs wrong");
  rst_pin_a: assert property (padGPullup[5] && !padGOe[5])
    else $error("reset pad wrong");
endmodule : port_efg_override_chk

bind port_efg_override port_efg_override_chk u_port_efg_override_chk (.*);

// ===== test/port_efg_override_bench.sv
// Purpose: random and corner stimulus for the port E/F/G override block
// Assumes: outputs read at the falling edge, after the registering edge
// Notes: expected pad bytes come from bench functions, unsure bits masked
`timescale 1ns/1ps
module port_efg_override_bench;
  import pin_override_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic clkIo, globalPullupDisable, receiverEnable, transmitterEnable, transmitSerialOut;
  logic usartSyncMode, syncClockOut, clockOutputFuse, serialIfaceTwoWireMode;
  logic serialIfaceThreeWireMode, serialDataOut, serialDataLow, serialClockHold;
  logic serialClockToggleStrobe, startConditionIrqEnable, pinChangeGroup0Enable;
  logic comparatorNegDigitalDisable, comparatorPosDigitalDisable, testPortEnable;
  logic tapShiftInstructionState, tapShiftDataState, testDataOut;
  logic [7:0] portEOut, portEDir, portFOut, portFDir, portGOut, portGDir;
  logic [7:0] pinChangeSourceE, padEIn, padFIn;
  logic [7:0] padEOe, padEOut, padEPullup, padEInEn, padFOe, padFOut, padFPullup, padFInEn;
  logic [7:0] padGOe, padGOut, padGPullup, padGInEn;
  logic usartReceiveData, usartSyncClockIn, testDataIn, testModeSelect, testClock;
  integer seed = 32'h4f63;
  int error_cnt = 0;
  int n_tests = 0;
  logic tog = 1'b0;
  logic sh;
  port_efg_override u_port_efg_override (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic setAll(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    {portEOut, portEDir, portFOut, portFDir} = a;
    {portGOut, portGDir, pinChangeSourceE, padEIn} = b;
    {padFIn, clkIo, globalPullupDisable, receiverEnable, transmitterEnable, transmitSerialOut,
      usartSyncMode, syncClockOut, clockOutputFuse, serialIfaceTwoWireMode,
      serialIfaceThreeWireMode, serialDataOut, serialDataLow, serialClockHold,
      serialClockToggleStrobe, startConditionIrqEnable, pinChangeGroup0Enable,
      comparatorNegDigitalDisable, comparatorPosDigitalDisable, testPortEnable,
      tapShiftInstructionState, tapShiftDataState, testDataOut} = c[29:0];
  endtask : setAll
  // plain port pull-up when nothing overrides the pad
  function automatic logic [7:0] pullDef(input logic [7:0] o, input logic [7:0] d);
    return o & ~d & {8{~globalPullupDisable}};
  endfunction : pullDef
  task automatic checkAll();
    logic [7:0] oe, ov, pu, ie, m, fo;
    oe = portEDir;
    oe[0] = portEDir[0] & ~receiverEnable;
    oe[1] = portEDir[1] | transmitterEnable;
    oe[7] = portEDir[7] | clockOutputFuse;
    ov = portEOut;
    ov[1] = transmitterEnable ? transmitSerialOut : portEOut[1];
    ov[2] = (usartSyncMode & portEDir[2]) ? syncClockOut : portEOut[2];
    ov[4] = portEOut[4] ^ tog;
    ov[5] = portEOut[5] & ~(serialIfaceTwoWireMode & portEDir[5]);
    ov[6] = serialIfaceThreeWireMode ? serialDataOut : portEOut[6];
    ov[7] = clockOutputFuse ? clkIo : portEOut[7];
    pu = pullDef(portEOut, portEDir);
    pu[0] = receiverEnable ? portEOut[0] & ~globalPullupDisable : pu[0];
    pu[1] = pu[1] & ~transmitterEnable;
    ie = 8'hFF;
    ie[3] = ~comparatorNegDigitalDisable | (pinChangeSourceE[3] & pinChangeGroup0Enable);
    ie[2] = ~comparatorPosDigitalDisable | (pinChangeSourceE[2] & pinChangeGroup0Enable);
    if (serialIfaceTwoWireMode) begin
      oe[4] = (serialClockHold | portEOut[4]) & portEDir[4];
      oe[5] = (serialDataLow | portEOut[5]) & portEDir[5];
      pu[5:4] = 2'b00;
    end
    m = (serialIfaceTwoWireMode & portEDir[4]) ? 8'hEF : 8'hFF;
    sh = tapShiftInstructionState | tapShiftDataState;
    // tdo: shifted data, else released high; other port F bits stay plain
    fo = portFOut;
    fo[6] = testPortEnable ? (sh ? testDataOut : 1'b1) : portFOut[6];
    chk("padEOe", oe, padEOe);
    chk("padEOut", ov & m, padEOut & m);
    chk("padEPullup", pu, padEPullup);
    chk("padEInEn", ie, padEInEn);
    chk("altIn", {6'h00, padEIn[0], padEIn[2]},
      {6'h00, usartReceiveData, usartSyncClockIn});
    chk("padFOe", testPortEnable ? {1'b0, sh, 2'b00, portFDir[3:0]} : portFDir,
      padFOe);
    chk("padFOut", fo, padFOut);
    chk("tapIn",
      {5'h00, {3{testPortEnable}} & {padFIn[7], padFIn[5:4]}},
      {5'h00, testDataIn, testModeSelect, testClock});
    chk("padFPullup", pullDef(portFOut, portFDir) | (testPortEnable ? 8'hF0 : 8'h00),
      padFPullup);
    chk("padFInEn", testPortEnable ? 8'h1F : 8'hFF, padFInEn);
    chk("padGOe", {portGDir[7:6], 1'b0, portGDir[4:0]}, padGOe);
    chk("padGOut", portGOut, padGOut);
    chk("padGPullup", pullDef(portGOut, portGDir) | 8'h20, padGPullup);
    chk("padGInEn", 8'hFF, padGInEn);
    chk("resetPad", 8'h02, {6'h00, padGPullup[5], padGOe[5]});
  endtask : checkAll
  task automatic step();
    tog = tog ^ serialClockToggleStrobe;
    @(negedge clk_sys);
    checkAll();
  endtask : step
  initial begin
    setAll(32'h0, 32'h0, 32'h0);
    testPortEnable = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("resetPull", 8'hB0, padFPullup & 8'hB0);
    chk("resetPad", 8'h02, {6'h00, padGPullup[5], padGOe[5]});
    rstn = 1'b1;
    step();
    // receiver overrides a set direction bit, strobe held for two edges
    receiverEnable = 1'b1;
    portEDir = 8'hFF;
    portEOut = 8'hFF;
    serialClockToggleStrobe = 1'b1;
    step();
    step();
    serialClockToggleStrobe = 1'b0;
    comparatorNegDigitalDisable = 1'b1;
    pinChangeSourceE = 8'h08;
    pinChangeGroup0Enable = 1'b1;
    step();
    $display("directed test done");
    // no conversion is modelled, so port F outputs may toggle freely
    repeat (3000) begin
      setAll($random(seed), $random(seed), $random(seed));
      step();
    end
    $display("random test done");
    complete_run();
  end
  // hang guard, far beyond the planned run
  initial begin
    #200us;
    error_cnt++;
    complete_run();
  end
endmodule : port_efg_override_bench
